//--- rtl/bus_grant_defs.svh
// constants for the external bus grant control
`ifndef BUS_GRANT_DEFS_SVH
`define BUS_GRANT_DEFS_SVH
`define SYNC_STAGES 2
`define ACT_HI 1'b1
`define ACT_LO 1'b0
`define PIN_COUNT 5
`define PIN_EMU_ON 4
`define PIN_REQ 3
`define PIN_EMU_REQ 2
`define PIN_RST 1
`define PIN_EMU_RST 0
`endif

//--- rtl/bus_grant_pkg.sv
// types for the external bus grant control
package bus_grant_pkg;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_ACCESS = 4'b0010,
    ST_GRANTED = 4'b0100,
    ST_HELD = 4'b1000
  } grant_state_t;
  typedef struct packed {
    logic req;
    logic rst;
  } pin_in_t;
  typedef struct packed {
    logic grant;
    logic grant_oe;
    logic emu_grant;
    logic stalled;
    logic float_bus;
    logic halt;
  } grant_out_t;
endpackage

//--- rtl/external_bus_grant_control.sv
// external bus grant arbiter for the processor memory bus
`timescale 1ns/100ps
`include "bus_grant_defs.svh"
module external_bus_grant_control
  import bus_grant_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic bus_request_n,
  input wire logic emulator_bus_request_n,
  input wire logic proc_reset,
  input wire logic emulator_reset,
  input wire logic emulator_enable,
  input wire logic run_while_granted,
  input wire logic access_active,
  input wire logic access_last,
  input wire logic access_needed,
  output logic bus_grant_n,
  output logic bus_grant_oe,
  output logic emulator_bus_grant_n,
  output logic grant_stalled_needs_bus_n,
  output logic mem_bus_oe,
  output logic core_halt,
  output logic core_reset
);
  // pin side inputs: both request lines, both resets, the enable strap
  logic [`PIN_COUNT-1:0] pins_raw;
  logic [`PIN_COUNT-1:0] pins_sync;
  pin_in_t sel;
  logic emu_on;
  grant_state_t state, next_state;
  grant_out_t outs, next_outs;
  logic granted;
  logic waiting;
  logic next_bus_grant_n;
  logic next_bus_grant_oe;
  logic next_emulator_bus_grant_n;
  logic next_grant_stalled_needs_bus_n;
  logic next_mem_bus_oe;
  logic next_core_halt;
  logic next_core_reset;

  // state decode shared by the next-state, output and check logic
  function automatic logic holds_bus(input grant_state_t s);
    return (s == ST_GRANTED) || (s == ST_HELD);
  endfunction

  function automatic logic mid_access(input logic active, input logic last);
    return active && !last;
  endfunction

  assign pins_raw = {emulator_enable, ~bus_request_n, ~emulator_bus_request_n, proc_reset, emulator_reset};

  sync_2ff #(.WIDTH(`PIN_COUNT)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d(pins_raw),
    .q(pins_sync)
  );

  assign emu_on = pins_sync[`PIN_EMU_ON];

  // all five pins share one synchroniser depth, so the selection never mixes ages
  always_comb begin
    sel.req = emu_on ? pins_sync[`PIN_EMU_REQ] : pins_sync[`PIN_REQ];
    sel.rst = emu_on ? pins_sync[`PIN_EMU_RST] : pins_sync[`PIN_RST];
  end

  // reset of this block is only power-on; the selected reset pin does not clear arbitration
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        // a request that meets the last access cycle is granted at the next edge
        if (mid_access(access_active, access_last)) begin
          next_state = ST_ACCESS;
        end else if (sel.req) begin
          next_state = ST_GRANTED;
        end
      end
      ST_ACCESS: begin
        // the access in flight always completes before the bus is handed over
        if (access_last) begin
          next_state = sel.req ? ST_GRANTED : ST_RUN;
        end
      end
      ST_GRANTED: begin
        if (!sel.req) begin
          next_state = ST_RUN;
        end else if (access_needed) begin
          next_state = ST_HELD;
        end
      end
      ST_HELD: begin
        if (!sel.req) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  assign granted = holds_bus(next_state);
  assign waiting = (next_state == ST_HELD);

  always_comb begin
    next_outs.grant = granted;
    next_outs.grant_oe = !emu_on;
    next_outs.emu_grant = granted && emu_on;
    next_outs.stalled = waiting;
    next_outs.float_bus = granted;
    // option trades bus latency for throughput: core runs until it must touch the bus
    next_outs.halt = granted && (!run_while_granted || waiting);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_RUN;
      outs <= '0;
    end else begin
      state <= next_state;
      outs <= next_outs;
    end
  end

  // pins leave from flops so the board never sees a decode glitch on grant or strobes
  always_comb begin
    next_bus_grant_n = !(next_outs.grant && !emu_on);
    next_bus_grant_oe = next_outs.grant_oe;
    next_emulator_bus_grant_n = !next_outs.emu_grant;
    next_grant_stalled_needs_bus_n = !next_outs.stalled;
    next_mem_bus_oe = !next_outs.float_bus;
    next_core_halt = next_outs.halt;
    // selected reset only passes through; it never clears the arbiter itself
    next_core_reset = sel.rst;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      bus_grant_n <= `ACT_HI;
      bus_grant_oe <= `ACT_LO;
      emulator_bus_grant_n <= `ACT_HI;
      grant_stalled_needs_bus_n <= `ACT_HI;
      mem_bus_oe <= `ACT_HI;
      core_halt <= `ACT_LO;
      core_reset <= `ACT_HI;
    end else begin
      bus_grant_n <= next_bus_grant_n;
      bus_grant_oe <= next_bus_grant_oe;
      emulator_bus_grant_n <= next_emulator_bus_grant_n;
      grant_stalled_needs_bus_n <= next_grant_stalled_needs_bus_n;
      mem_bus_oe <= next_mem_bus_oe;
      core_halt <= next_core_halt;
      core_reset <= next_core_reset;
    end
  end

  sequence s_req_idle;
    sel.req && state == ST_RUN && !mid_access(access_active, access_last);
  endsequence

  sequence s_stall_return;
    !grant_stalled_needs_bus_n && !sel.req;
  endsequence

  sequence s_bus_back;
    grant_stalled_needs_bus_n && bus_grant_n && emulator_bus_grant_n && mem_bus_oe && !core_halt;
  endsequence

  a_grant_idle_req: assert property (@(posedge mclk) disable iff (rst)
    s_req_idle |=> outs.grant && !mem_bus_oe) else $error("idle request not granted next cycle");
  a_float_while_grant: assert property (@(posedge mclk) disable iff (rst)
    outs.grant |-> !mem_bus_oe) else $error("bus driven while granted");
  a_go_mode_runs: assert property (@(posedge mclk) disable iff (rst)
    (outs.grant && run_while_granted && !outs.stalled && $past(run_while_granted)) |-> !core_halt)
    else $error("core halted in run-while-granted");
  a_no_grant_in_access: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_ACCESS && !access_last) |=> !outs.grant) else $error("grant during access");
  a_grant_after_access: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_ACCESS && access_last && sel.req) |=> outs.grant) else $error("late grant after access");
  a_release_grant: assert property (@(posedge mclk) disable iff (rst)
    (outs.grant && !sel.req) |=> !outs.grant && mem_bus_oe && !core_halt) else $error("release failed");
  a_stall_flag: assert property (@(posedge mclk) disable iff (rst)
    (state == ST_GRANTED && sel.req && access_needed) |=> !grant_stalled_needs_bus_n && core_halt)
    else $error("stall flag missing");
  a_return_clears: assert property (@(posedge mclk) disable iff (rst)
    (outs.stalled && !sel.req) |=> grant_stalled_needs_bus_n && bus_grant_n) else $error("return not seen");
  a_emu_floats_grant: assert property (@(posedge mclk) disable iff (rst)
    ($past(emu_on) && emu_on) |-> !bus_grant_oe && bus_grant_n) else $error("normal grant driven under emulation");
  a_grant_mid_instr: assert property (@(posedge mclk) disable iff (rst)
    s_req_idle ##0 access_needed |=> outs.grant) else $error("grant held back for instruction");
  a_req_under_reset: assert property (@(posedge mclk) disable iff (rst)
    s_req_idle ##0 sel.rst |=> outs.grant) else $error("arbitration blocked by core reset");
  a_reset_passes: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> core_reset == $past(sel.rst)) else $error("core reset not passed through");
  a_stall_needs_grant: assert property (@(posedge mclk) disable iff (rst)
    !grant_stalled_needs_bus_n |-> outs.grant) else $error("stalled output without grant");
  a_halt_needs_grant: assert property (@(posedge mclk) disable iff (rst)
    core_halt |-> holds_bus(state)) else $error("core halted without grant");
  a_emu_grant_gated: assert property (@(posedge mclk) disable iff (rst)
    !emulator_bus_grant_n |-> outs.grant && $past(emu_on)) else $error("emulator grant off emulation");
  a_held_return: assert property (@(posedge mclk) disable iff (rst)
    s_stall_return |=> s_bus_back) else $error("returned bus not taken back");
  a_grant_after_sync: assert property (@(posedge mclk) disable iff (rst)
    $rose(outs.grant) |-> $past(sel.req)) else $error("grant without synchronised request");
endmodule

//--- rtl/sync_2ff.sv
// two-stage level synchroniser, one per bit
`timescale 1ns/100ps
`include "bus_grant_defs.svh"
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage [`SYNC_STAGES];
  logic [WIDTH-1:0] next_stage [`SYNC_STAGES];
  genvar i;
  always_comb begin
    next_stage[0] = d;
  end
  generate
    for (i = 1; i < `SYNC_STAGES; i++) begin : g_chain
      always_comb begin
        next_stage[i] = stage[i-1];
      end
    end
  endgenerate
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < `SYNC_STAGES; k++) begin
        stage[k] <= '0;
      end
    end else begin
      stage <= next_stage;
    end
  end
  assign q = stage[`SYNC_STAGES-1];
endmodule

//--- tb/ext_master.sv
// far-side bus master model for the grant arbiter
`timescale 1ns/100ps
module ext_master (
  input wire logic mclk,
  input wire logic want,
  input wire logic grant_stalled_needs_bus_n,
  output logic req_n
);
  initial req_n = 1'b1;
  // request stands while wanted; a stalled core makes the master drop its request at the next edge
  always @(posedge mclk) begin
    req_n <= #1 !(want && grant_stalled_needs_bus_n);
  end
endmodule

//--- tb/testbench.sv
// self-checking bench for the external bus grant arbiter
`timescale 1ns/100ps
module testbench;
  logic mclk, rst, want, preq_n, prst, erst, emu, rwg, aa, al, an;
  logic grant_n, grant_oe, egrant_n, st_n, mbo, halt, crst;
  int miscompares = 0;
  int n_compared = 0;
  int r;
  int mq[$];
  int cur;
  int mst;
  logic mvalid = 1'b0;
  logic xg, xemu, xrwg, xrst;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ext_master i_master (.mclk(mclk), .want(want), .grant_stalled_needs_bus_n(st_n), .req_n(preq_n));
  external_bus_grant_control i_dut (.mclk(mclk), .rst(rst), .bus_request_n(emu ? 1'b1 : preq_n),
    .emulator_bus_request_n(emu ? preq_n : 1'b1), .proc_reset(prst), .emulator_reset(erst),
    .emulator_enable(emu), .run_while_granted(rwg), .access_active(aa), .access_last(al),
    .access_needed(an), .bus_grant_n(grant_n), .bus_grant_oe(grant_oe), .emulator_bus_grant_n(egrant_n),
    .grant_stalled_needs_bus_n(st_n), .mem_bus_oe(mbo), .core_halt(halt), .core_reset(crst));
  task automatic summarize();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic e, input logic g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // bounded wait on grant (0) or emulator grant (1)
  task automatic wait_on(input int k, input logic v);
    for (int i = 0; i < 12; i++) begin
      if ((k == 0 ? grant_n : egrant_n) === v) return;
      tick(1);
    end
    chk("wait", v, !v);
    summarize();
  endtask
  // reference model: selected reset, enable and request pass a two-deep queue like the pin synchroniser
  always @(posedge mclk) begin
    if (rst) begin
      mq = '{0, 0};
      mst = 0;
      mvalid = 1'b0;
    end else begin
      cur = mq.pop_front();
      mq.push_back(4 * (emu ? erst : prst) + 2 * emu + !preq_n);
      case (mst)
        0: mst = (aa && !al) ? 1 : (cur % 2 == 1 ? 2 : 0);
        1: mst = !al ? 1 : (cur % 2 == 1 ? 2 : 0);
        2: mst = cur % 2 == 0 ? 0 : (an ? 3 : 2);
        default: mst = cur % 2 == 1 ? 3 : 0;
      endcase
      xg = mst >= 2;
      xemu = cur / 2 % 2 == 1;
      xrst = cur / 4 == 1;
      xrwg = rwg;
      mvalid = 1'b1;
    end
  end
  // outputs settle at the rising edge; the model is compared half a period later
  always @(negedge mclk) begin
    if (mvalid && !rst) begin
      chk("model bus_grant_n", !(xg && !xemu), grant_n);
      chk("model bus_grant_oe", !xemu, grant_oe);
      chk("model emulator_bus_grant_n", !(xg && xemu), egrant_n);
      chk("model stalled_n", mst != 3, st_n);
      chk("model mem_bus_oe", !xg, mbo);
      chk("model core_halt", xg && (!xrwg || mst == 3), halt);
      chk("model core_reset", xrst, crst);
    end
  end
  initial begin
    {want, prst, erst, emu, rwg, aa, al, an} = '0;
    rst = 1'b1;
    void'($urandom(32'h0de2));
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    tick(2);
    for (r = 0; r < 2; r++) begin
      rwg = r[0];
      want = 1'b1;
      wait_on(0, 1'b0);
      chk("mem_bus_oe", 1'b0, mbo);
      chk("core_halt", !rwg, halt);
      an = 1'b1;
      tick(1);
      chk("stalled_n", 1'b0, st_n);
      chk("core_halt", 1'b1, halt);
      want = 1'b0;
      wait_on(0, 1'b1);
      chk("stalled_n", 1'b1, st_n);
      chk("mem_bus_oe", 1'b1, mbo);
      chk("core_halt", 1'b0, halt);
      an = 1'b0;
    end
    // request held off by an access of random length
    aa = 1'b1;
    want = 1'b1;
    tick(3 + $urandom_range(2, 6));
    chk("bus_grant_n", 1'b1, grant_n);
    al = 1'b1;
    tick(1);
    {aa, al} = '0;
    chk("bus_grant_n", 1'b0, grant_n);
    want = 1'b0;
    wait_on(0, 1'b1);
    // arbitration still alive under reset
    prst = 1'b1;
    want = 1'b1;
    wait_on(0, 1'b0);
    chk("core_reset", 1'b1, crst);
    want = 1'b0;
    wait_on(0, 1'b1);
    prst = 1'b0;
    emu = 1'b1;
    erst = 1'b1;
    tick(3);
    chk("core_reset", 1'b1, crst);
    erst = 1'b0;
    want = 1'b1;
    wait_on(1, 1'b0);
    chk("bus_grant_oe", 1'b0, grant_oe);
    chk("bus_grant_n", 1'b1, grant_n);
    want = 1'b0;
    wait_on(1, 1'b1);
    summarize();
  end
endmodule
